//--- bench/hspw_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
module hspw_mcu_model
    import hspw_pkg::*;
(
    input wire logic sys_clk,
    output logic cfgWrite,
    output logic scratchWrite,
    output hspw_word_t writeData
);
    // Idle strobes at time zero
    initial begin
        cfgWrite = 1'b0;
        scratchWrite = 1'b0;
        writeData = 16'h0000;
    end
    // Words go out back to back; strobe stays high so it never toggles twice in a step
    task automatic send(input logic toCfg, input hspw_word_t w[$]);
        cfgWrite = toCfg;
        scratchWrite = !toCfg;
        foreach (w[i]) begin
            writeData = w[i];
            @(posedge sys_clk);
            #10;
        end
        cfgWrite = 1'b0;
        scratchWrite = 1'b0;
        writeData = ~writeData; // Stale data flips so nothing latches it by luck
    endtask
endmodule // hspw_mcu_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import hspw_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic softReset = 1'b0;
    hspw_mode_t devMode = HSPW_NORMAL;
    logic cfgWrite;
    logic scratchWrite;
    hspw_word_t writeData;
    logic [15:0] cfgReadData;
    logic [15:0] scratchReadData;
    logic [3:0] hsOut;
    int n_errors = 0;
    int n_compared = 0;
    int n;
    // 10 MHz
    always #50 sys_clk = ~sys_clk;
    hspw_mcu_model mcu (.sys_clk(sys_clk), .cfgWrite(cfgWrite), .scratchWrite(scratchWrite), .writeData(writeData));
    hspw_top dut (.sys_clk(sys_clk), .reset(reset), .softReset(softReset), .devMode(devMode), .cfgWrite(cfgWrite),
        .scratchWrite(scratchWrite), .writeData(writeData), .cfgReadData(cfgReadData),
        .scratchReadData(scratchReadData), .highside_switch_output(hsOut));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Read ports lag a write by two edges
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #10;
    endtask
    // Cycles until an output reaches a level; running out of the bound ends the run
    task automatic wait_out(input int b, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (hsOut[b] !== lvl) begin
            @(posedge sys_clk);
            #10;
            cnt++;
            if (cnt > lim) begin
                n_errors++;
                $display("MISMATCH t=%0t output wait ran out", $time);
                print_verdict();
            end
        end
    endtask
    task automatic test_reset();
        check(cfgReadData, 16'h0000);
        check(scratchReadData, 16'h0000);
        check(hsOut, 4'h0);
    endtask
    task automatic test_readback();
        mcu.send(1'b1, '{16'hfff9});
        settle();
        check(cfgReadData, 16'h7ff1);
    endtask
    // Duty loaded before any output is watched; a don't-care write must not reach gen0
    task automatic test_generators();
        mcu.send(1'b1, '{16'h4020, 16'h3ff1, 16'h0002, 16'h7ff3, 16'h0004});
        settle();
        check(cfgReadData, 16'h0004);
        wait_out(0, 1'b0, 200, n);
        wait_out(0, 1'b1, 50000, n);
        check(hsOut[3:1], 3'b101);
        wait_out(0, 1'b0, 200, n);
        check(n, 96);
        wait_out(0, 1'b1, 50000, n);
        check(n + 96, 49152);
        check(hsOut[3:1], 3'b101);
        // Full duty on generator 0 must reach its channel; one sample is taken four edges after the write
        mcu.send(1'b1, '{16'h3ff0});
        settle();
        settle();
        check(hsOut[0], 1'b1);
    endtask
    task automatic test_scratch();
        hspw_mode_t m[2];
        m = '{HSPW_RESTART, HSPW_FAILSAFE};
        mcu.send(1'b0, '{16'ha5c3});
        settle();
        check(scratchReadData, 16'ha5c3);
        foreach (m[i]) begin
            devMode = m[i];
            mcu.send(1'b0, '{16'h1234});
            settle();
            check(scratchReadData, 16'h0000);
        end
        devMode = HSPW_NORMAL;
        settle();
        check(scratchReadData, 16'ha5c3);
        softReset = 1'b1;
        mcu.send(1'b0, '{16'hffff});
        softReset = 1'b0;
        settle();
        check(scratchReadData, 16'h0000);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #10;
        reset = 1'b0;
        test_reset();
        test_readback();
        test_scratch();
        test_generators();
        print_verdict();
    end
endmodule // tb
`default_nettype wire

//--- hw/hspw_generator.sv
`timescale 1ns/100ps
`default_nettype none
`include "hspw_map.svh"
module hspw_generator
    import hspw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic periodFast,
    input wire hspw_duty_t duty,
    output logic pwmOut
);
    logic [6:0] tick_r, tick_nxt;
    logic [9:0] phase_r, phase_nxt;
    logic pwmOut_r, pwmOut_nxt;
    logic [6:0] tickLast;

    // Step prescaler: the enable for the 1024-step phase counter
    always_comb begin
        tickLast = periodFast ? 7'(`HSPW_TICK_FAST - 1) : 7'(`HSPW_TICK_SLOW - 1);
        tick_nxt = (tick_r >= tickLast) ? 7'h00 : tick_r + 7'h01;
        phase_nxt = (tick_r >= tickLast) ? phase_r + 10'h001 : phase_r;
        // All ones is forced on rather than giving 1023/1024
        if (duty == 10'h3ff) begin
            pwmOut_nxt = 1'b1;
        end else begin
            pwmOut_nxt = phase_r < duty;
        end
    end

    // Duty is sampled live, so a change mid-period may give one odd pulse
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick_r <= 7'h00;
            phase_r <= 10'h000;
            pwmOut_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
            phase_r <= phase_nxt;
            pwmOut_r <= pwmOut_nxt;
        end
    end
    assign pwmOut = pwmOut_r;

    property p_gen_off;
        @(posedge sys_clk) disable iff (reset)
        (duty == 10'h000) [*2] |-> !pwmOut;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("Output high at zero duty");

    property p_gen_on;
        @(posedge sys_clk) disable iff (reset)
        (duty == 10'h3ff) [*2] |-> pwmOut;
    endproperty
    a_gen_on: assert property (p_gen_on) else $error("Output low at full duty");

    property p_tick_bound;
        @(posedge sys_clk) disable iff (reset)
        periodFast [*2] |-> tick_r <= 7'(`HSPW_TICK_FAST - 1);
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("Fast prescaler overran");
endmodule // hspw_generator
`default_nettype wire

//--- hw/hspw_map.svh
`ifndef HSPW_MAP_SVH
`define HSPW_MAP_SVH
`define HSPW_CFG_RESET 16'h0000
`define HSPW_SCR_RESET 16'h0000
`define HSPW_FREQ_BIT 14
`define HSPW_DUTY_MSB 13
`define HSPW_DUTY_LSB 4
`define HSPW_SEL_MSB 2
`define HSPW_CFG_RDMASK 16'h7ff7
`define HSPW_CLK_HZ 10000000
`define HSPW_SLOW_HZ 100
`define HSPW_FAST_HZ 200
`define HSPW_STEPS 1024
// Clocks per duty step; 100 Hz gives 97 cycles, rounded down
`define HSPW_TICK_SLOW (`HSPW_CLK_HZ / (`HSPW_SLOW_HZ * `HSPW_STEPS))
`define HSPW_TICK_FAST (`HSPW_CLK_HZ / (`HSPW_FAST_HZ * `HSPW_STEPS))
`endif

//--- hw/hspw_pkg.sv
package hspw_pkg;
    typedef logic [9:0] hspw_duty_t;
    typedef logic [15:0] hspw_word_t;
    typedef enum logic [2:0] {
        HSPW_NORMAL = 3'b001,
        HSPW_RESTART = 3'b010,
        HSPW_FAILSAFE = 3'b100
    } hspw_mode_t;
endpackage

//--- hw/hspw_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "hspw_map.svh"
module hspw_top
    import hspw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic softReset,
    input wire hspw_mode_t devMode,
    input wire logic cfgWrite,
    input wire logic scratchWrite,
    input wire hspw_word_t writeData,
    output logic [15:0] cfgReadData,
    output logic [15:0] scratchReadData,
    output logic [3:0] highside_switch_output
);
    logic [3:0] fast_r, fast_nxt;
    hspw_duty_t duty_r [4];
    hspw_duty_t duty_nxt [4];
    logic [15:0] cfgShadow_r, cfgShadow_nxt;
    logic [15:0] scratch_r, scratch_nxt;
    logic [15:0] cfgRd_r, scrRd_r;
    logic [3:0] genOut;
    logic [3:0] hsOut_r;
    logic isNormal;

    assign isNormal = (devMode == HSPW_NORMAL);

    // Register writes; select bit 2 set means the write reaches no generator
    always_comb begin
        fast_nxt = fast_r;
        cfgShadow_nxt = cfgShadow_r;
        for (int g = 0; g < 4; g++) begin
            duty_nxt[g] = duty_r[g];
        end
        if (cfgWrite) begin
            cfgShadow_nxt = writeData & `HSPW_CFG_RDMASK;
            if (!writeData[`HSPW_SEL_MSB]) begin
                fast_nxt[writeData[1:0]] = writeData[`HSPW_FREQ_BIT];
                duty_nxt[writeData[1:0]] = writeData[`HSPW_DUTY_MSB:`HSPW_DUTY_LSB];
            end
        end
        // Scratch word written only in normal mode; softReset clears it in any mode and wins over a write
        scratch_nxt = scratch_r;
        if (softReset) begin
            scratch_nxt = `HSPW_SCR_RESET;
        end else if (scratchWrite && isNormal) begin
            scratch_nxt = writeData;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fast_r <= 4'h0;
            for (int g = 0; g < 4; g++) begin
                duty_r[g] <= 10'h000;
            end
            cfgShadow_r <= `HSPW_CFG_RESET;
            scratch_r <= `HSPW_SCR_RESET;
        end else begin
            fast_r <= fast_nxt;
            duty_r <= duty_nxt;
            cfgShadow_r <= cfgShadow_nxt;
            scratch_r <= scratch_nxt;
        end
    end

    // One generator per high-side channel
    generate
        for (genvar g = 0; g < 4; g++) begin : gen_mod
            hspw_generator internal_modulator_n (
                .sys_clk(sys_clk),
                .reset(reset),
                .periodFast(fast_r[g]),
                .duty(duty_r[g]),
                .pwmOut(genOut[g])
            );
        end
    endgenerate

    // Read data and outputs registered; scratch reads zero outside normal mode
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfgRd_r <= 16'h0000;
            scrRd_r <= 16'h0000;
            hsOut_r <= 4'h0;
        end else begin
            cfgRd_r <= cfgShadow_r & `HSPW_CFG_RDMASK;
            scrRd_r <= isNormal ? scratch_r : 16'h0000;
            hsOut_r <= genOut;
        end
    end
    assign cfgReadData = cfgRd_r;
    assign scratchReadData = scrRd_r;
    assign highside_switch_output = hsOut_r;

    property p_res_zero;
        @(posedge sys_clk) disable iff (reset)
        cfgReadData[15] == 1'b0 && cfgReadData[3] == 1'b0;
    endproperty
    a_res_zero: assert property (p_res_zero) else $error("Reserved bit read nonzero");

    property p_scr_hold;
        @(posedge sys_clk) disable iff (reset)
        (!isNormal && !softReset) |=> scratch_r == $past(scratch_r);
    endproperty
    a_scr_hold: assert property (p_scr_hold) else $error("Scratch changed outside normal mode");

    property p_scr_write;
        @(posedge sys_clk) disable iff (reset)
        (scratchWrite && isNormal && !softReset) |=> scratch_r == $past(writeData);
    endproperty
    a_scr_write: assert property (p_scr_write) else $error("Scratch write lost");

    property p_scr_clear;
        @(posedge sys_clk) disable iff (reset)
        softReset |=> scratch_r == 16'h0000;
    endproperty
    a_scr_clear: assert property (p_scr_clear) else $error("Soft reset left scratch set");

    property p_dc_ignore;
        @(posedge sys_clk) disable iff (reset)
        (cfgWrite && writeData[2]) |=> fast_r == $past(fast_r) && duty_r[0] == $past(duty_r[0]);
    endproperty
    a_dc_ignore: assert property (p_dc_ignore) else $error("Don't-care select changed a generator");

    property p_duty_load;
        @(posedge sys_clk) disable iff (reset)
        (cfgWrite && writeData[2:0] == 3'b001) |=> duty_r[1] == $past(writeData[13:4]);
    endproperty
    a_duty_load: assert property (p_duty_load) else $error("Duty not loaded");

    property p_freq_load;
        @(posedge sys_clk) disable iff (reset)
        (cfgWrite && writeData[2:0] == 3'b011) |=> fast_r[3] == $past(writeData[14]);
    endproperty
    a_freq_load: assert property (p_freq_load) else $error("Period select not loaded");

    sequence s_full_on;
        (duty_r[0] == 10'h3ff) [*3];
    endsequence
    property p_out_on;
        @(posedge sys_clk) disable iff (reset)
        s_full_on |-> highside_switch_output[0];
    endproperty
    a_out_on: assert property (p_out_on) else $error("Channel 0 not on at full duty");
endmodule // hspw_top
`default_nettype wire
